// ==== csm_pkg.sv ====
// Purpose: Constants and types for the search match and burst register block.
// Assumes: AHB-Lite register access, 32-bit words, single 20 MHz clock.
// Notes:   68-bit registers are split over three words (low, mid, high).
//
// Functional notes
// - ID register bits 3:0 hold revision number, starting at one.
// - ID register holds device code in 15:8, maker code in 31:16, rest reserved; here bits 6:4 carry IMPL_NUM and bit 7 reads zero.
// - Burst read starts at read burst address and adds one per location.
// - Read burst length in 27:19, 4 to 511, counts down per location.
// - Burst write starts at write burst address and adds one per location.
// - Write burst length in 27:19, 4 to 511, counts down per location.
// - In 68-bit mode bit zero of each entry flags occupied (one) or free.
// - Each write or learn updates next free address to lowest free entry.
// - When all entries are occupied both full output bits go high.
// - In 136-bit mode next free address bit zero stays zero.
// - Bit matches if global mask zero, local mask zero, or search equals data.
// - 68-bit quadrant wins only if all 68 bits of one entry match.
// - 136-bit quadrant hit needs even entry and following odd entry to match.
// - 272-bit quadrant hit needs four aligned consecutive entries to match.
// - Only the global winner drives SRAM bus and both result signals; here last devices also drive whenever this device is not the winner.
// - On no hit, last-in-cascade and last-on-SRAM devices drive those outputs.
// - Miss gives flag low, valid high; non-search cycles drive both low.
// - Table splits into four quadrants, each of independent width.
// - Quadrant width field: 00 is 68, 01 is 136, 10 is 272, 11 reserved.
package csm_pkg;
  localparam int          ENTRY_W       = 68;
  localparam int          ADDR_W        = 14;
  localparam int          BURST_LENGTH_W        = 9;
  localparam int          BURST_LENGTH_LSB      = 19;
  localparam int          SRAM_W        = 22;
  localparam logic [3:0]  REV_NUM       = 4'h1;
  // Identity codes: arbitrary values, not those of any real part
  localparam logic [2:0]  IMPL_NUM      = 3'h0;
  localparam logic [7:0]  DEV_CODE      = 8'h5a;
  localparam logic [15:0] MAKER_CODE    = 16'h0a5c;
  // Register byte addresses
  localparam logic [7:0]  A_ID          = 8'h00;
  localparam logic [7:0]  A_RBUR        = 8'h10;
  localparam logic [7:0]  A_WBUR        = 8'h20;
  localparam logic [7:0]  A_CFG         = 8'h30;
  localparam logic [7:0]  A_STAT        = 8'h40;
  localparam logic [7:0]  A_NFA         = 8'h60;
  localparam int          CFG_LAST_DEV  = 7;
  localparam int          CFG_LAST_SRAM = 8;
  localparam int          CFG_QW_LSB    = 9;
  localparam logic [SRAM_W-1:0] SRAM_IDLE = 22'h3f_ffff;
  typedef enum logic [1:0] {QW_68 = 2'b00, QW_136 = 2'b01, QW_272 = 2'b10, QW_RSV = 2'b11}
    csm_qwidth_t;
  typedef enum logic [1:0] {BUS_IDLE, BUS_RD, BUS_WR} csm_acc_t;
endpackage

// ==== csm_search.sv ====
// Purpose: Search match, arbitration, occupancy tracking and burst registers.
// Assumes: Small parameterised table; host commands as strobes; AHB-Lite slave.
// Notes:   One-cycle search; table array is a register array.
//
// The AHB-Lite interface to the registers was chosen for this implementation.
module csm_search
  import csm_pkg::*;
#(
  parameter int ENTRIES = 16
)(
  input  wire logic                        clk,
  input  wire logic                        rst,
  input  wire logic                        hsel,
  input  wire logic [31:0]                 haddr,
  input  wire logic [1:0]                  htrans,
  input  wire logic                        hwrite,
  input  wire logic [2:0]                  hsize,
  input  wire logic [31:0]                 hwdata,
  input  wire logic                        hready,
  output logic                             hreadyout,
  output logic                             hresp,
  output logic [31:0]                      hrdata,
  input  wire logic                        ent_wr,
  input  wire logic                        ent_learn,
  input  wire logic                        ent_burst,
  input  wire logic [$clog2(ENTRIES)-1:0]  ent_addr,
  input  wire logic [csm_pkg::ENTRY_W-1:0] ent_data,
  input  wire logic [csm_pkg::ENTRY_W-1:0] ent_mask,
  input  wire logic                        burst_rd_step,
  output logic [csm_pkg::ADDR_W-1:0]       burst_rd_addr,
  output logic [csm_pkg::ADDR_W-1:0]       burst_wr_addr,
  input  wire logic                        srch,
  input  wire logic [csm_pkg::ENTRY_W-1:0] srch_key,
  input  wire logic [csm_pkg::ENTRY_W-1:0] gmask,
  input  wire logic                        cascade_win_in,
  output logic                             local_win,
  output logic                             search_successful_flag,
  output logic                             search_result_valid,
  output logic                             rslt_oe,
  output logic [csm_pkg::SRAM_W-1:0]       sram_address_out,
  output logic                             sram_oe,
  output logic [1:0]                       table_full_output
);
  import csm_pkg::*;
  localparam int AW = $clog2(ENTRIES);
  localparam int QSZ = ENTRIES / 4;

  logic [ENTRY_W-1:0]    data_q [ENTRIES];
  logic [ENTRY_W-1:0]    mask_q [ENTRIES];
  logic [27:0]           rbur_q;
  logic [27:0]           wbur_q;
  logic [16:0]           cfg_q;
  logic [ADDR_W-1:0]     nfa_q;
  logic                  full_q;
  logic                  ssf_q;
  logic                  ssv_q;
  logic                  roe_q;
  logic [SRAM_W-1:0]     sram_address_out_q;
  logic                  soe_q;
  logic [ENTRIES-1:0]    ent_ok;
  logic [ENTRIES-1:0]    grp_ok;
  logic                  hit;
  logic [AW-1:0]         hit_idx;
  logic [ENTRIES-1:0]    occ;
  logic [ADDR_W-1:0]     nfa_d;
  logic                  full_d;
  csm_acc_t              acc_q;
  logic [7:0]            aoff_q;
  logic                  wr_rbur;
  logic                  wr_wbur;

  // Per-entry bit match: g=0 or m=0 forces match
  always_comb
  begin
    for (int e = 0; e < ENTRIES; e++)
      ent_ok[e] = &(~gmask | ~mask_q[e] | ~(srch_key ^ data_q[e]));
  end

  // Group entries per quadrant width; every member of the aligned group must match
  always_comb
  begin
    csm_qwidth_t qw;
    qw = QW_68;
    for (int e = 0; e < ENTRIES; e++)
    begin
      qw = csm_qwidth_t'(cfg_q[CFG_QW_LSB + 2*(e/QSZ) +: 2]);
      case (qw)
        QW_68:   grp_ok[e] = ent_ok[e];
        QW_136:  grp_ok[e] = (e % 2 == 0) && ent_ok[e] && ent_ok[(e+1) % ENTRIES];
        QW_272:  grp_ok[e] = (e % 4 == 0) && (&ent_ok[(e/4)*4 +: 4]);
        default: grp_ok[e] = 1'b0;
      endcase
    end
  end

  // Lowest index wins locally
  always_comb
  begin
    hit = 1'b0;
    hit_idx = '0;
    for (int e = ENTRIES-1; e >= 0; e--)
      if (grp_ok[e])
      begin
        hit = 1'b1;
        hit_idx = AW'(e);
      end
  end

  assign local_win = srch && hit;

  // Result drive: global winner, else last device defaults
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ssf_q  <= 1'b0;
      ssv_q  <= 1'b0;
      roe_q  <= 1'b0;
      sram_address_out_q <= SRAM_IDLE;
      soe_q  <= 1'b0;
    end
    else if (srch && hit && cascade_win_in)
    begin
      ssf_q  <= 1'b1;
      ssv_q  <= 1'b1;
      roe_q  <= 1'b1;
      sram_address_out_q <= SRAM_W'(hit_idx);
      soe_q  <= 1'b1;
    end
    else
    begin
      // Winner elsewhere, or miss: only last devices drive defaults
      ssf_q  <= 1'b0;
      ssv_q  <= srch && !cascade_win_in;
      roe_q  <= cfg_q[CFG_LAST_DEV];
      sram_address_out_q <= SRAM_IDLE;
      soe_q  <= cfg_q[CFG_LAST_SRAM];
    end
  end

  assign search_successful_flag = ssf_q;
  assign search_result_valid    = ssv_q;
  assign rslt_oe                = roe_q;
  assign sram_address_out       = sram_address_out_q;
  assign sram_oe                = soe_q;

  // Table write port
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      for (int e = 0; e < ENTRIES; e++)
      begin
        data_q[e] <= '0;
        mask_q[e] <= '0;
      end
    end
    else if (ent_learn)
    begin
      data_q[AW'(nfa_q)] <= ent_data | ENTRY_W'(1);
      mask_q[AW'(nfa_q)] <= ent_mask;
    end
    else if (ent_wr)
    begin
      data_q[ent_burst ? AW'(wbur_q[ADDR_W-1:0]) : ent_addr] <= ent_data;
      mask_q[ent_burst ? AW'(wbur_q[ADDR_W-1:0]) : ent_addr] <= ent_mask;
    end
  end

  // Lowest free location, with 136-bit pairing forcing even index
  always_comb
  begin
    nfa_d = '0;
    for (int e = 0; e < ENTRIES; e++)
      occ[e] = data_q[e][0];
    full_d = &occ;
    for (int e = ENTRIES-1; e >= 0; e--)
      if (!occ[e])
        nfa_d = ADDR_W'(e);
    if (csm_qwidth_t'(cfg_q[CFG_QW_LSB + 2*(int'(nfa_d)/QSZ) +: 2]) == QW_136)
      nfa_d[0] = 1'b0;
  end

  // Recomputed from the updated table one cycle after each write or learn
  logic upd_q;
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      upd_q  <= 1'b0;
      nfa_q  <= '0;
      full_q <= 1'b0;
    end
    else
    begin
      upd_q <= ent_wr || ent_learn;
      if (upd_q)
      begin
        nfa_q  <= nfa_d;
        full_q <= full_d;
      end
    end
  end

  assign table_full_output = {2{full_q}};

  // AHB-Lite slave: zero wait states, always OKAY
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      acc_q  <= BUS_IDLE;
      aoff_q <= '0;
    end
    else if (hready)
    begin
      acc_q  <= (hsel && htrans[1]) ? (hwrite ? BUS_WR : BUS_RD) : BUS_IDLE;
      aoff_q <= haddr[7:0];
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign wr_rbur   = (acc_q == BUS_WR) && (aoff_q == A_RBUR);
  assign wr_wbur   = (acc_q == BUS_WR) && (aoff_q == A_WBUR);

  // Burst registers: software load, hardware step
  always_ff @(posedge clk)
  begin
    if (rst)
      rbur_q <= '0;
    else if (wr_rbur)
      rbur_q <= {hwdata[27:19], 5'h0, hwdata[13:0]};
    else if (burst_rd_step && rbur_q[27:BURST_LENGTH_LSB] != '0)
    begin
      rbur_q[ADDR_W-1:0]      <= rbur_q[ADDR_W-1:0] + ADDR_W'(1);
      rbur_q[27:BURST_LENGTH_LSB]     <= rbur_q[27:BURST_LENGTH_LSB] - BURST_LENGTH_W'(1);
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      wbur_q <= '0;
    else if (wr_wbur)
      wbur_q <= {hwdata[27:19], 5'h0, hwdata[13:0]};
    else if (ent_wr && ent_burst && wbur_q[27:BURST_LENGTH_LSB] != '0)
    begin
      wbur_q[ADDR_W-1:0]      <= wbur_q[ADDR_W-1:0] + ADDR_W'(1);
      wbur_q[27:BURST_LENGTH_LSB]     <= wbur_q[27:BURST_LENGTH_LSB] - BURST_LENGTH_W'(1);
    end
  end

  assign burst_rd_addr = rbur_q[ADDR_W-1:0];
  assign burst_wr_addr = wbur_q[ADDR_W-1:0];

  always_ff @(posedge clk)
  begin
    if (rst)
      cfg_q <= '0;
    else if ((acc_q == BUS_WR) && (aoff_q == A_CFG))
      cfg_q <= {hwdata[16:7], 7'h0};
  end

  // Read data; ID and next free address have no write path
  always_comb
  begin
    hrdata = '0;
    if (acc_q == BUS_RD)
      case (aoff_q)
        A_ID:    hrdata = {MAKER_CODE, DEV_CODE, 1'b0, IMPL_NUM, REV_NUM};
        A_RBUR:  hrdata = {4'h0, rbur_q};
        A_WBUR:  hrdata = {4'h0, wbur_q};
        A_CFG:   hrdata = {15'h0, cfg_q};
        A_STAT:  hrdata = {30'h0, table_full_output};
        A_NFA:   hrdata = {18'h0, nfa_q};
        default: hrdata = '0;
      endcase
  end

  a_burst_rd_step: assert property (@(posedge clk) disable iff (rst)
    burst_rd_step && !wr_rbur && rbur_q[27:19] != 0 |=>
      rbur_q[13:0] == $past(rbur_q[13:0]) + 14'h1 && rbur_q[27:19] == $past(rbur_q[27:19]) - 9'h1)
    else $error("read burst step wrong");
  a_burst_wr_step: assert property (@(posedge clk) disable iff (rst)
    ent_wr && ent_burst && !ent_learn && !wr_wbur && wbur_q[27:19] != 0 |=>
      wbur_q[13:0] == $past(wbur_q[13:0]) + 14'h1)
    else $error("write burst step wrong");
  a_burst_len_down: assert property (@(posedge clk) disable iff (rst)
    ent_wr && ent_burst && !wr_wbur && wbur_q[27:19] != 0 |=>
      wbur_q[27:19] == $past(wbur_q[27:19]) - 9'h1)
    else $error("write length not decremented");
  a_full_both: assert property (@(posedge clk) disable iff (rst)
    table_full_output[0] == table_full_output[1])
    else $error("full bits differ");
  a_full_cause: assert property (@(posedge clk) disable iff (rst)
    upd_q |=> table_full_output == {2{$past(full_d)}})
    else $error("full output wrong");
  a_nfa_free: assert property (@(posedge clk) disable iff (rst)
    upd_q && !full_d |=> !occ[AW'(nfa_q)] || nfa_q[0] == 1'b0)
    else $error("next free address occupied");
  a_miss_valid: assert property (@(posedge clk) disable iff (rst)
    srch && !cascade_win_in |=> search_result_valid && !search_successful_flag)
    else $error("miss result wrong");
  a_idle_low: assert property (@(posedge clk) disable iff (rst)
    !srch |=> !search_result_valid && !search_successful_flag)
    else $error("idle result not low");
  a_win_drive: assert property (@(posedge clk) disable iff (rst)
    srch && hit && cascade_win_in |=> rslt_oe && sram_oe && search_successful_flag)
    else $error("winner not driving");
  a_id_const: assert property (@(posedge clk) disable iff (rst)
    acc_q == BUS_RD && aoff_q == A_ID |-> hrdata[3:0] == 4'h1)
    else $error("revision wrong");
  c_hit: cover property (@(posedge clk) srch && hit && cascade_win_in);
  c_miss: cover property (@(posedge clk) srch && !hit);
  c_full: cover property (@(posedge clk) table_full_output == 2'b11);
  c_burst_end: cover property (@(posedge clk) burst_rd_step && rbur_q[27:19] == 9'h1);
endmodule // csm_search

// ==== csm_host.sv ====
// Purpose: Host controller model driving the register bus and entry/search strobes.
// Assumes: One AHB-Lite slave; hready is that slave's hreadyout.
// Notes:   Signals change by nba just after a rising edge; released data is inverted.
module csm_host (
  input  wire logic        clk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata,
  output logic             ent_wr,
  output logic             ent_learn,
  output logic             ent_burst,
  output logic [3:0]       ent_addr,
  output logic [67:0]      ent_data,
  output logic [67:0]      ent_mask,
  output logic             srch,
  output logic [67:0]      srch_key,
  output logic [67:0]      gmask
);
  timeunit 1ns;
  timeprecision 1ns;
  import csm_pkg::*;
  initial
  begin
    {hsel, htrans, hwrite, hsize, haddr, hwdata, ent_wr, ent_learn, ent_burst} = '0;
    {ent_addr, ent_data, ent_mask, srch, srch_key, gmask} = '0;
  end
  // Bounded waits; a stuck hready ends the run through the bench's report
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    int n;
    n = 0;
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= wr;
    hsize  <= 3'h2;
    do @(posedge clk); while (!hready && ++n < 64);
    htrans <= 2'b00;
    hsel   <= 1'b0;
    hwdata <= wr ? wd : ~hwdata;
    // Data phase held until hready is seen high at a rising edge; read data taken there
    do @(posedge clk); while (!hready && ++n < 64);
    rd = hrdata;
    if (n >= 64)
    begin
      tb_top.fails++;
      tb_top.conclude();
    end
  endtask
  task automatic ent(input logic wr, lrn, bst, input logic [3:0] a, input logic [67:0] d, m);
    ent_wr    <= wr;
    ent_learn <= lrn;
    ent_burst <= bst;
    ent_addr  <= a;
    ent_data  <= d;
    ent_mask  <= m;
    @(posedge clk);
  endtask
  task automatic idle();
    ent_wr    <= 1'b0;
    ent_learn <= 1'b0;
    ent_burst <= 1'b0;
    ent_data  <= ~ent_data;
    @(posedge clk);
  endtask
  task automatic find(input logic [67:0] k, gm);
    srch     <= 1'b1;
    srch_key <= k;
    gmask    <= gm;
    @(posedge clk);
    srch     <= 1'b0;
    srch_key <= ~k;
  endtask
endmodule // csm_host

// ==== tb_top.sv ====
// Purpose: Self-checking bench for the search match and burst register block.
// Assumes: Sixteen entries; quadrants 68 bits unless a test sets otherwise.
// Notes:   Expectations come from the model arrays md, mm and occ.
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import csm_pkg::*;
  localparam logic [31:0] ID_EXP = {MAKER_CODE, DEV_CODE, 1'b0, IMPL_NUM, REV_NUM};
  logic        clk, rst, hsel, hwrite, hreadyout, hresp, ent_wr, ent_learn, ent_burst, srch;
  logic        burst_rd_step, cascade_win_in, local_win, rslt_oe, sram_oe, w;
  logic        search_successful_flag, search_result_valid;
  logic [1:0]  htrans, table_full_output;
  logic [2:0]  hsize;
  logic [3:0]  ent_addr;
  logic [13:0] burst_rd_addr, burst_wr_addr, ra;
  logic [16:0] cfg;
  logic [21:0] sram_address_out;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [67:0] ent_data, ent_mask, srch_key, gmask, key, g;
  logic [67:0] md[16], mm[16];
  bit          occ[16];
  int          fails, checks, seed, i, j, h;
  csm_search #(.ENTRIES(16)) uut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .ent_wr(ent_wr),
    .ent_learn(ent_learn), .ent_burst(ent_burst), .ent_addr(ent_addr), .ent_data(ent_data),
    .ent_mask(ent_mask), .burst_rd_step(burst_rd_step), .burst_rd_addr(burst_rd_addr),
    .burst_wr_addr(burst_wr_addr), .srch(srch), .srch_key(srch_key), .gmask(gmask),
    .cascade_win_in(cascade_win_in), .local_win(local_win),
    .search_successful_flag(search_successful_flag), .search_result_valid(search_result_valid),
    .rslt_oe(rslt_oe), .sram_address_out(sram_address_out), .sram_oe(sram_oe),
    .table_full_output(table_full_output));
  csm_host u_host (.clk(clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .ent_wr(ent_wr),
    .ent_learn(ent_learn), .ent_burst(ent_burst), .ent_addr(ent_addr), .ent_data(ent_data),
    .ent_mask(ent_mask), .srch(srch), .srch_key(srch_key), .gmask(gmask));
  task automatic chk(input logic [67:0] got, exp);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Lowest free entry; pairs in 136-bit mode so the index is kept even
  function automatic int nfa_m();
    int n;
    n = 16;
    for (int k = 15; k >= 0; k--)
      if (!occ[k]) n = k;
    return (cfg[10:9] == 2'b01) ? (n & ~1) : n;
  endfunction
  function automatic int hit_m(input logic [67:0] s, gm);
    for (int k = 0; k < 16; k++)
      if ((gm & mm[k] & (s ^ md[k])) == 68'h0) return k;
    return -1;
  endfunction
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    conclude();
  end
  initial
  begin
    seed = 35;
    rst = 1'b1;
    burst_rd_step = 1'b0;
    cascade_win_in = 1'b0;
    cfg = '0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    u_host.bus(1'b0, A_ID, 0, rd);
    chk(rd, ID_EXP);
    u_host.bus(1'b1, A_ID, $random(seed), rd);
    u_host.bus(1'b1, A_NFA, 32'h0000_0005, rd);
    u_host.bus(1'b0, A_ID, 0, rd);
    chk(rd, ID_EXP);
    u_host.bus(1'b0, A_NFA, 0, rd);
    chk(rd, 0);
    u_host.bus(1'b0, 8'h7c, 0, rd);
    chk(rd, 0);
    chk(hresp, 1'b0);
    $display("identity test done");
    ra = 14'($random(seed));
    u_host.bus(1'b1, A_RBUR, {4'h0, 9'd4, 5'h0, ra}, rd);
    burst_rd_step <= 1'b1;
    repeat (5) @(posedge clk);
    burst_rd_step <= 1'b0;
    @(negedge clk);
    chk(burst_rd_addr, {ra + 14'd4});
    u_host.bus(1'b0, A_RBUR, 0, rd);
    chk(rd, {18'h0, ra + 14'd4});
    for (i = 0; i < 16; i++)
    begin
      md[i] = 68'({$random(seed), $random(seed), $random(seed)} & ~96'h1);
      mm[i] = (i == 4) ? ~(68'h1 << 20) : ~68'h0;
      u_host.ent(1'b1, 1'b0, 1'b0, i[3:0], md[i], mm[i]);
    end
    u_host.idle();
    u_host.bus(1'b1, A_WBUR, {4'h0, 9'd4, 5'h0, 14'd2}, rd);
    for (i = 2; i < 6; i++)
    begin
      md[i][0] = 1'b1;
      occ[i] = 1'b1;
      u_host.ent(1'b1, 1'b0, 1'b1, 4'h0, md[i], mm[i]);
    end
    u_host.idle();
    @(negedge clk);
    chk(burst_wr_addr, 14'd6);
    u_host.bus(1'b0, A_WBUR, 0, rd);
    chk(rd, 32'h0000_0006);
    md[0][0] = 1'b1;
    occ[0] = 1'b1;
    u_host.ent(1'b1, 1'b0, 1'b0, 4'h0, md[0], mm[0]);
    u_host.idle();
    u_host.bus(1'b0, A_NFA, 0, rd);
    chk(rd, 68'(nfa_m()));
    $display("burst test done");
    for (j = 0; j < 8; j++)
    begin
      cfg = j[0] ? 17'h0_0180 : 17'h0_0000;
      u_host.bus(1'b1, A_CFG, {15'h0, cfg}, rd);
      key = (j % 4 == 0) ? md[3] : (j % 4 == 1) ? md[3] ^ (68'h1 << 40) :
            (j % 4 == 2) ? md[4] ^ (68'h1 << 20) : 68'({$random(seed), $random(seed), $random(seed)});
      g = (j % 4 == 1) ? ~(68'h1 << 40) : ~68'h0;
      h = hit_m(key, g);
      w = (h >= 0) && (j < 4);
      cascade_win_in <= w;
      u_host.find(key, g);
      @(negedge clk);
      chk({search_successful_flag, search_result_valid, rslt_oe, sram_oe, sram_address_out},
          w ? {4'hf, 22'(h)} : {2'b01, cfg[7], cfg[8], SRAM_IDLE});
      @(negedge clk);
      chk({search_successful_flag, search_result_valid}, 2'b00);
      @(posedge clk);
    end
    $display("search test done");
    cfg = 17'h0_aa00;
    u_host.bus(1'b1, A_CFG, {15'h0, cfg}, rd);
    for (i = 6; i < 8; i++)
    begin
      md[i][0] = 1'b1;
      occ[i] = 1'b1;
      u_host.ent(1'b1, 1'b0, 1'b0, i[3:0], md[i], mm[i]);
    end
    u_host.idle();
    u_host.bus(1'b0, A_NFA, 0, rd);
    chk(rd, 68'(nfa_m()));
    cfg = '0;
    u_host.bus(1'b1, A_CFG, 0, rd);
    md[7][0] = 1'b1;
    occ[7] = 1'b1;
    u_host.ent(1'b1, 1'b0, 1'b0, 4'h7, md[7], mm[7]);
    u_host.idle();
    // Nine entries are still free here: learn until every one is taken
    for (i = 7; i < 16; i++)
    begin
      chk(table_full_output, 2'b00);
      h = nfa_m();
      u_host.ent(1'b0, 1'b1, 1'b0, 4'h0, md[i], mm[i]);
      u_host.idle();
      occ[h] = 1'b1;
      u_host.bus(1'b0, A_NFA, 0, rd);
      if (i < 15) chk(rd, 68'(nfa_m()));
    end
    @(negedge clk);
    chk(table_full_output, 2'b11);
    u_host.bus(1'b0, A_STAT, 0, rd);
    chk(rd[1:0], 2'b11);
    $display("occupancy test done");
    conclude();
  end
endmodule // tb_top
